// *** rtl/lcr_bpv_trigger.sv ***
// module: samples violation bits on transmit clock edges, one pulse per rise
`timescale 1ns/1ps
module lcr_bpv_trigger #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // filtered transmit clock levels and register bits
    input wire logic [W-1:0] tx_clk_level_i,
    input wire logic [W-1:0] viol_bit_i,
    // one-cycle insertion requests
    output logic [W-1:0] insert_o
);
    logic [W-1:0] clk_prev_reg;
    logic [W-1:0] viol_smp_reg;
    logic [W-1:0] clk_rise;

    // rising edge of each channel's transmit clock
    assign clk_rise = tx_clk_level_i & ~clk_prev_reg;

    // sample only on the clock edge so one write gives one violation
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_prev_reg <= '0;
            viol_smp_reg <= '0;
            insert_o <= '0;
        end else begin
            clk_prev_reg <= tx_clk_level_i;
            for (int i = 0; i < W; i++) begin
                if (clk_rise[i]) begin
                    viol_smp_reg[i] <= viol_bit_i[i]; // RL13
                    insert_o[i] <= viol_bit_i[i] & ~viol_smp_reg[i]; // RL12
                end else begin
                    insert_o[i] <= 1'b0;
                end
            end
        end
    end
endmodule : lcr_bpv_trigger

// *** rtl/lcr_channel_regs.sv ***
// module: per-channel line configuration registers and their decoded controls
//
// Functional notes
// [RL1] E1 bandwidth 10 or 1.5 Hz; T1 3 Hz
// [RL2] depth bit picks 32 or 64 bit fifo
// [RL3] fifo delay is half the depth
// [RL4] one depth serves receive and transmit fifo
// [RL5] inversion bit swaps which pattern is inverted
// [RL6] test field picks none, QRSS or all ones
// [RL7] transmitter on needs bit and global pin
// [RL8] transmit bit resets to zero, transmitter off
// [RL9] loop field picks none, dual, analog, remote, digital
// [RL10] coding bit: HDB3/B8ZS clear, AMI set; code gives AMI only in single rail
// [RL11] resistor field reports fitted external resistor
// [RL12] each violation bit rise inserts one violation
// [RL13] violation bit sampled on transmit clock rise
// [RL14] software writes zero before writing one
// [RL15] fourteen register copies spaced 0x10 apart
// [RL16] coding bits 7:6 reserved, writable, reset zero
// [RL17] violation bit taken into transmit clock timing
`timescale 1ns/1ps
module lcr_channel_regs #(
    parameter int NUM_CH = lcr_pkg::NUM_CH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // host register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic rd_valid_o,
    // device pins
    input wire logic global_tx_enable_pin_i,
    input wire logic [NUM_CH-1:0] transmit_clock_i,
    // per-channel operating mode from other blocks
    input wire logic [NUM_CH-1:0] e1_mode_i,
    input wire logic [NUM_CH-1:0] single_rail_i,
    input wire logic [NUM_CH-1:0] prbs_mode_i,
    // jitter attenuator controls
    output logic [NUM_CH-1:0][1:0] jitter_bw_o,
    output logic [NUM_CH-1:0][6:0] rx_fifo_depth_o,
    output logic [NUM_CH-1:0][6:0] tx_fifo_depth_o,
    output logic [NUM_CH-1:0][6:0] fifo_delay_o,
    // transmit controls
    output logic [NUM_CH-1:0][1:0] tx_pattern_select_o,
    output logic [NUM_CH-1:0] pattern_invert_o,
    output logic [NUM_CH-1:0] tx_power_on_o,
    output logic [NUM_CH-1:0] violation_insert_o,
    // line and loop controls
    output logic [NUM_CH-1:0][2:0] loop_mode_o,
    output logic [NUM_CH-1:0] ami_coding_o,
    output logic [NUM_CH-1:0][7:0] rx_resistor_ohms_o
);
    logic [7:0] jitter_reg [NUM_CH];
    logic [7:0] test_loop_reg [NUM_CH];
    logic [7:0] coding_reg [NUM_CH];
    logic [3:0] acc_sel;
    logic [3:0] acc_ch;
    logic global_en;
    logic [NUM_CH-1:0] tx_clk_level;
    logic [NUM_CH-1:0] viol_bits;

    // register select from a byte address; zero means unmapped
    function automatic logic [3:0] reg_select(input logic [7:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        if (a[7:4] >= 4'(NUM_CH)) begin
            sel = 4'h0;
        end else if (a[3:0] == lcr_pkg::REG_JITTER) begin
            sel = lcr_pkg::REG_JITTER;
        end else if (a[3:0] == lcr_pkg::REG_TEST_LOOP) begin
            sel = lcr_pkg::REG_TEST_LOOP;
        end else if (a[3:0] == lcr_pkg::REG_CODING) begin
            sel = lcr_pkg::REG_CODING;
        end
        return sel;
    endfunction : reg_select

    // fifo depth in bits from the depth bit
    function automatic logic [6:0] fifo_depth(input logic deep);
        return deep ? lcr_pkg::FIFO_DEPTH_DEEP : lcr_pkg::FIFO_DEPTH_SHALLOW;
    endfunction : fifo_depth

    // upper nibble is the channel, lower the register
    assign acc_sel = reg_select(addr_i); // RL15
    assign acc_ch = addr_i[7:4];

    // global transmit enable and transmit clocks come from pins
    lcr_pin_sync #(
        .W(1)
    ) u_en_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(global_tx_enable_pin_i),
        .level_o(global_en)
    );

    lcr_pin_sync #(
        .W(NUM_CH)
    ) u_clk_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(transmit_clock_i),
        .level_o(tx_clk_level)
    );

    // host writes; all bits writable, reserved bits included
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                jitter_reg[c] <= lcr_pkg::RST_JITTER;
                test_loop_reg[c] <= lcr_pkg::RST_TEST_LOOP; // RL8
                coding_reg[c] <= lcr_pkg::RST_CODING; // RL16
            end
        end else if (wr_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (acc_ch == 4'(c)) begin
                    if (acc_sel == lcr_pkg::REG_JITTER) begin
                        jitter_reg[c] <= wdata_i;
                    end else if (acc_sel == lcr_pkg::REG_TEST_LOOP) begin
                        test_loop_reg[c] <= wdata_i;
                    end else if (acc_sel == lcr_pkg::REG_CODING) begin
                        coding_reg[c] <= wdata_i;
                    end
                end
            end
        end
    end

    // host reads, answered one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= lcr_pkg::REG_UNMAPPED_DATA;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_i;
            if (!rd_i) begin
                rdata_o <= lcr_pkg::REG_UNMAPPED_DATA;
            end else if (acc_sel == lcr_pkg::REG_JITTER) begin
                rdata_o <= jitter_reg[acc_ch];
            end else if (acc_sel == lcr_pkg::REG_TEST_LOOP) begin
                rdata_o <= test_loop_reg[acc_ch];
            end else if (acc_sel == lcr_pkg::REG_CODING) begin
                rdata_o <= coding_reg[acc_ch];
            end else begin
                rdata_o <= lcr_pkg::REG_UNMAPPED_DATA;
            end
        end
    end

    // jitter attenuator settings; one depth feeds both fifo_depth_select
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            jitter_bw_o <= '0;
            rx_fifo_depth_o <= '0;
            tx_fifo_depth_o <= '0;
            fifo_delay_o <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (!e1_mode_i[c]) begin
                    jitter_bw_o[c] <= lcr_pkg::JA_BW_3HZ; // RL1
                end else if (jitter_reg[c][lcr_pkg::BIT_JA_BW]) begin
                    jitter_bw_o[c] <= lcr_pkg::JA_BW_1P5HZ; // RL1
                end else begin
                    jitter_bw_o[c] <= lcr_pkg::JA_BW_10HZ; // RL1
                end
                rx_fifo_depth_o[c] <=
                    fifo_depth(jitter_reg[c][lcr_pkg::BIT_FIFO_DEPTH]); // RL2
                tx_fifo_depth_o[c] <=
                    fifo_depth(jitter_reg[c][lcr_pkg::BIT_FIFO_DEPTH]); // RL4
                fifo_delay_o[c] <=
                    fifo_depth(jitter_reg[c][lcr_pkg::BIT_FIFO_DEPTH]) >> 1; // RL3
            end
        end
    end

    // test pattern, inversion and transmitter power
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_pattern_select_o <= '0;
            pattern_invert_o <= '0;
            tx_power_on_o <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                case (test_loop_reg[c][lcr_pkg::TX_PAT_HI:lcr_pkg::TX_PAT_LO])
                    3'b100: tx_pattern_select_o[c] <= lcr_pkg::PAT_QRSS; // RL6
                    3'b101: tx_pattern_select_o[c] <= lcr_pkg::PAT_ALL_ONES;
                    3'b110, 3'b111: begin
                        tx_pattern_select_o[c] <= lcr_pkg::PAT_RESERVED;
                    end
                    default: tx_pattern_select_o[c] <= lcr_pkg::PAT_NONE;
                endcase
                // clear bit inverts qrss only, set bit inverts prbs only
                pattern_invert_o[c] <= prbs_mode_i[c] ~^
                    test_loop_reg[c][lcr_pkg::BIT_PAT_INV]; // RL5
                // pin low overrides every channel bit
                tx_power_on_o[c] <= global_en &
                    test_loop_reg[c][lcr_pkg::BIT_TX_ON]; // RL7
            end
        end
    end

    // loopback, line coding and resistor report
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loop_mode_o <= '0;
            ami_coding_o <= '0;
            rx_resistor_ohms_o <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                case (test_loop_reg[c][lcr_pkg::LOOP_HI:lcr_pkg::LOOP_LO])
                    3'b100: loop_mode_o[c] <= lcr_pkg::LOOP_DUAL; // RL9
                    3'b101: loop_mode_o[c] <= lcr_pkg::LOOP_ANALOG;
                    3'b110: loop_mode_o[c] <= lcr_pkg::LOOP_REMOTE;
                    3'b111: loop_mode_o[c] <= lcr_pkg::LOOP_DIGITAL;
                    default: loop_mode_o[c] <= lcr_pkg::LOOP_NONE;
                endcase
                // dual rail carries no encoder, so ami only in single rail
                ami_coding_o[c] <= single_rail_i[c] &
                    coding_reg[c][lcr_pkg::BIT_LINE_CODE]; // RL10
                case (coding_reg[c][lcr_pkg::RES_HI:lcr_pkg::RES_LO])
                    2'b01: rx_resistor_ohms_o[c] <= lcr_pkg::RES_OHM_240; // RL11
                    2'b10: rx_resistor_ohms_o[c] <= lcr_pkg::RES_OHM_210;
                    2'b11: rx_resistor_ohms_o[c] <= lcr_pkg::RES_OHM_150;
                    default: rx_resistor_ohms_o[c] <= lcr_pkg::RES_OHM_NONE;
                endcase
            end
        end
    end

    // violation bits sampled in transmit clock timing, not on host write
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            viol_bits[c] = coding_reg[c][lcr_pkg::BIT_VIOL];
        end
    end

    lcr_bpv_trigger #(
        .W(NUM_CH)
    ) u_bpv (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tx_clk_level_i(tx_clk_level),
        .viol_bit_i(viol_bits),
        .insert_o(violation_insert_o) // RL17
    );

    // checks on channel 0, except pin-off on all channels and stride on channel 13
    AST_T1_BW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
        !e1_mode_i[0] |=> jitter_bw_o[0] == lcr_pkg::JA_BW_3HZ)
        else $error("T1 bandwidth not 3 Hz");

    AST_FIFO_HALF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL3
        7'(fifo_delay_o[0] << 1) == rx_fifo_depth_o[0]
        || rx_fifo_depth_o[0] == 7'h00)
        else $error("fifo delay not half of depth");

    AST_FIFO_BOTH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
        rx_fifo_depth_o[0] == tx_fifo_depth_o[0])
        else $error("receive and transmit fifo depths differ");

    AST_FIFO_DEPTH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        jitter_reg[0][lcr_pkg::BIT_FIFO_DEPTH] ##1
        jitter_reg[0][lcr_pkg::BIT_FIFO_DEPTH]
        |-> rx_fifo_depth_o[0] == lcr_pkg::FIFO_DEPTH_DEEP)
        else $error("deep fifo not selected");

    AST_INVERT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL5
        (!prbs_mode_i[0] && !test_loop_reg[0][lcr_pkg::BIT_PAT_INV])
        |=> pattern_invert_o[0])
        else $error("qrss not inverted by default");

    AST_PATTERN: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        !test_loop_reg[0][lcr_pkg::TX_PAT_HI]
        |=> tx_pattern_select_o[0] == lcr_pkg::PAT_NONE)
        else $error("pattern sent with field msb clear");

    AST_TX_PIN_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL7
        !global_en |=> tx_power_on_o == '0)
        else $error("transmitter powered with pin low");

    AST_TX_NEEDS_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL8
        tx_power_on_o[0] |-> $past(test_loop_reg[0][lcr_pkg::BIT_TX_ON]))
        else $error("transmitter powered without its bit");

    AST_LOOP_NONE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL9
        !test_loop_reg[0][lcr_pkg::LOOP_HI]
        |=> loop_mode_o[0] == lcr_pkg::LOOP_NONE)
        else $error("loopback active with field msb clear");

    AST_AMI: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL10
        ami_coding_o[0] |-> $past(coding_reg[0][lcr_pkg::BIT_LINE_CODE]))
        else $error("ami coding without its bit");

    AST_RES_NONE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL11
        coding_reg[0][lcr_pkg::RES_HI:lcr_pkg::RES_LO] == 2'b00
        |=> rx_resistor_ohms_o[0] == lcr_pkg::RES_OHM_NONE)
        else $error("resistor reported when none fitted");

    AST_BPV_ONCE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL12
        violation_insert_o[0] |=> !violation_insert_o[0] [*2])
        else $error("violation inserted twice for one rise");

    AST_BPV_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL13
        violation_insert_o[0] |-> $past(tx_clk_level[0])
        && $past(coding_reg[0][lcr_pkg::BIT_VIOL]))
        else $error("violation without clock edge and bit");

    AST_RSVD_RW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL16
        (wr_i && acc_sel == lcr_pkg::REG_CODING && acc_ch == 4'h0)
        |=> coding_reg[0][lcr_pkg::RSVD_HI:lcr_pkg::RSVD_LO]
        == $past(wdata_i[lcr_pkg::RSVD_HI:lcr_pkg::RSVD_LO]))
        else $error("reserved coding bits not stored");

    AST_STRIDE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL15
        (rd_i && addr_i == 8'hD3) |=> rdata_o == $past(coding_reg[13]))
        else $error("channel 13 coding register misplaced");
endmodule : lcr_channel_regs

// *** rtl/lcr_pin_sync.sv ***
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lcr_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // asynchronous pins and filtered level
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // shift chain; first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level_o[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : lcr_pin_sync

// *** rtl/lcr_pkg.sv ***
// package: layout and line_code_select of the per-channel line configuration registers
package lcr_pkg;
    // channel count and register map
    localparam int NUM_CH = 14;
    localparam logic [3:0] REG_JITTER = 4'h1;
    localparam logic [3:0] REG_TEST_LOOP = 4'h2;
    localparam logic [3:0] REG_CODING = 4'h3;
    localparam logic [7:0] REG_UNMAPPED_DATA = 8'h00;

    // reset values
    localparam logic [7:0] RST_JITTER = 8'h00;
    localparam logic [7:0] RST_TEST_LOOP = 8'h00;
    localparam logic [7:0] RST_CODING = 8'h00;

    // field positions, jitter register
    localparam int BIT_JA_BW = 1;
    localparam int BIT_FIFO_DEPTH = 0;
    // field positions, test and loop register
    localparam int BIT_PAT_INV = 7;
    localparam int TX_PAT_HI = 6;
    localparam int TX_PAT_LO = 4;
    localparam int BIT_TX_ON = 3;
    localparam int LOOP_HI = 2;
    localparam int LOOP_LO = 0;
    // field positions, coding register
    localparam int RSVD_HI = 7;
    localparam int RSVD_LO = 6;
    localparam int BIT_LINE_CODE = 5;
    localparam int RES_HI = 4;
    localparam int RES_LO = 3;
    localparam int BIT_VIOL = 2;

    // jitter attenuator fifo depths in bits
    localparam logic [6:0] FIFO_DEPTH_SHALLOW = 7'h20;
    localparam logic [6:0] FIFO_DEPTH_DEEP = 7'h40;

    // external receive resistor values in ohms
    localparam logic [7:0] RES_OHM_NONE = 8'h00;
    localparam logic [7:0] RES_OHM_240 = 8'hF0;
    localparam logic [7:0] RES_OHM_210 = 8'hD2;
    localparam logic [7:0] RES_OHM_150 = 8'h96;

    // jitter attenuator bandwidth
    typedef enum logic [1:0] {
        JA_BW_3HZ,
        JA_BW_10HZ,
        JA_BW_1P5HZ
    } lcr_ja_bw_t;

    // transmit test pattern
    typedef enum logic [1:0] {
        PAT_NONE,
        PAT_QRSS,
        PAT_ALL_ONES,
        PAT_RESERVED
    } lcr_pattern_t;

    // loopback mode
    typedef enum logic [2:0] {
        LOOP_NONE,
        LOOP_DUAL,
        LOOP_ANALOG,
        LOOP_REMOTE,
        LOOP_DIGITAL
    } lcr_loop_t;
endpackage : lcr_pkg

// *** tb/lcr_channel_regs_tb.sv ***
// testbench: host access and decoded controls of the channel registers
`timescale 1ns/1ps
module lcr_channel_regs_tb;
    localparam int NCH = lcr_pkg::NUM_CH;
    // clock, reset and host port
    logic clk_i;
    logic rst_n_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic rd_valid_o;
    // pins and operating modes
    logic global_tx_enable_pin_i;
    logic [NCH-1:0] transmit_clock_i;
    logic [NCH-1:0] e1_mode_i;
    logic [NCH-1:0] single_rail_i;
    logic [NCH-1:0] prbs_mode_i;
    // decoded controls
    logic [NCH-1:0][1:0] jitter_bw_o;
    logic [NCH-1:0][6:0] rx_fifo_depth_o;
    logic [NCH-1:0][6:0] tx_fifo_depth_o;
    logic [NCH-1:0][6:0] fifo_delay_o;
    logic [NCH-1:0][1:0] tx_pattern_select_o;
    logic [NCH-1:0] pattern_invert_o;
    logic [NCH-1:0] tx_power_on_o;
    logic [NCH-1:0] violation_insert_o;
    logic [NCH-1:0][2:0] loop_mode_o;
    logic [NCH-1:0] ami_coding_o;
    logic [NCH-1:0][7:0] rx_resistor_ohms_o;
    int errors;
    int n_compared;

    lcr_channel_regs #(.NUM_CH(NCH)) lcr_channel_regs_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rd_valid_o(rd_valid_o),
        .global_tx_enable_pin_i(global_tx_enable_pin_i),
        .transmit_clock_i(transmit_clock_i), .e1_mode_i(e1_mode_i),
        .single_rail_i(single_rail_i), .prbs_mode_i(prbs_mode_i),
        .jitter_bw_o(jitter_bw_o), .rx_fifo_depth_o(rx_fifo_depth_o),
        .tx_fifo_depth_o(tx_fifo_depth_o), .fifo_delay_o(fifo_delay_o),
        .tx_pattern_select_o(tx_pattern_select_o),
        .pattern_invert_o(pattern_invert_o),
        .tx_power_on_o(tx_power_on_o),
        .violation_insert_o(violation_insert_o),
        .loop_mode_o(loop_mode_o), .ami_coding_o(ami_coding_o),
        .rx_resistor_ohms_o(rx_resistor_ohms_o)
    );

    // 10 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cycles

    // one-cycle write strobe, inputs moved on the falling edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clk_i);
        wr_i = 1'b0;
    endtask : reg_wr

    // answer stands one cycle, so it is looked at one cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_i);
        rd_i = 1'b0;
        chk("read valid", 8'(rd_valid_o), 8'h01);
        chk($sformatf("register %h", a), rdata_o, exp);
    endtask : rd_chk

    // slow transmit clock, 12 system cycles a period; counts every pulse
    task automatic transmit_clock_run(input int ch, input int periods, output int hits);
        hits = 0;
        repeat (2 * periods) begin
            transmit_clock_i[ch] = ~transmit_clock_i[ch];
            repeat (6) begin
                @(negedge clk_i);
                hits += $countones(violation_insert_o);
            end
        end
    endtask : transmit_clock_run

    function automatic logic [7:0] exp_pat(input logic [2:0] c);
        case (c)
            3'b100: return 8'(lcr_pkg::PAT_QRSS);
            3'b101: return 8'(lcr_pkg::PAT_ALL_ONES);
            3'b110, 3'b111: return 8'(lcr_pkg::PAT_RESERVED);
            default: return 8'(lcr_pkg::PAT_NONE);
        endcase
    endfunction : exp_pat

    function automatic logic [7:0] exp_loop(input logic [2:0] c);
        case (c)
            3'b100: return 8'(lcr_pkg::LOOP_DUAL);
            3'b101: return 8'(lcr_pkg::LOOP_ANALOG);
            3'b110: return 8'(lcr_pkg::LOOP_REMOTE);
            3'b111: return 8'(lcr_pkg::LOOP_DIGITAL);
            default: return 8'(lcr_pkg::LOOP_NONE);
        endcase
    endfunction : exp_loop

    function automatic logic [7:0] exp_ohm(input logic [1:0] c);
        case (c)
            2'b01: return lcr_pkg::RES_OHM_240;
            2'b10: return lcr_pkg::RES_OHM_210;
            2'b11: return lcr_pkg::RES_OHM_150;
            default: return lcr_pkg::RES_OHM_NONE;
        endcase
    endfunction : exp_ohm

    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #5000000;
        errors++;
        final_report();
    end

    // main sequence
    initial begin
        int hits;
        logic [7:0] v;
        logic [7:0] dep;
        logic [7:0] bw;
        errors = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        global_tx_enable_pin_i = 1'b1;
        transmit_clock_i = '0;
        e1_mode_i = '0;
        single_rail_i = '0;
        prbs_mode_i = '0;
        cycles(5);
        rst_n_i = 1'b1;
        cycles(6);
        // reset state: pin high yet every transmitter stays off
        for (int c = 0; c < NCH; c++) begin
            chk("tx power at reset", 8'(tx_power_on_o[c]), 8'h00);
        end
        for (int r = 1; r < 4; r++) begin
            rd_chk(8'(r), 8'h00);
            rd_chk(8'(8'hD0 + r), 8'h00);
        end
        // jitter register, both line modes and all bit pairs
        for (int k = 0; k < 8; k++) begin
            e1_mode_i[13] = k[2];
            v = {k[2:0], 3'b000, k[1:0]};
            reg_wr(8'hD1, v);
            reg_wr(8'h01, v);
            cycles(3);
            bw = !k[2] ? 8'(lcr_pkg::JA_BW_3HZ) :
                (k[1] ? 8'(lcr_pkg::JA_BW_1P5HZ) : 8'(lcr_pkg::JA_BW_10HZ));
            dep = k[0] ? 8'(lcr_pkg::FIFO_DEPTH_DEEP) :
                8'(lcr_pkg::FIFO_DEPTH_SHALLOW);
            chk("jitter bw", 8'(jitter_bw_o[13]), bw);
            chk("rx depth", 8'(rx_fifo_depth_o[13]), dep);
            chk("tx depth", 8'(tx_fifo_depth_o[13]), dep);
            chk("fifo delay", 8'(fifo_delay_o[13]), dep >> 1);
            chk("rx depth ch0", 8'(rx_fifo_depth_o[0]), dep);
            rd_chk(8'hD1, v);
        end
        // every pattern and loop code, all inversion cases
        for (int k = 0; k < 8; k++) begin
            prbs_mode_i[0] = k[1];
            v = {k[0], k[2:0], 1'b1, 3'(7 - k)};
            reg_wr(8'h02, v);
            cycles(3);
            chk("pattern", 8'(tx_pattern_select_o[0]), exp_pat(k[2:0]));
            chk("loop", 8'(loop_mode_o[0]), exp_loop(3'(7 - k)));
            chk("invert", 8'(pattern_invert_o[0]),
                8'(k[1] ? k[0] : !k[0]));
        end
        // transmitter power needs both the bit and the global pin
        cycles(4);
        chk("tx power on", 8'(tx_power_on_o[0]), 8'h01);
        chk("tx power unset", 8'(tx_power_on_o[5]), 8'h00);
        global_tx_enable_pin_i = 1'b0;
        cycles(6);
        chk("tx power pin low", 8'(tx_power_on_o[0]), 8'h00);
        global_tx_enable_pin_i = 1'b1;
        cycles(6);
        chk("tx power pin high", 8'(tx_power_on_o[0]), 8'h01);
        // coding register: line code, resistor line_code_select, reserved storage
        for (int k = 0; k < 4; k++) begin
            single_rail_i[7] = k[1];
            v = {k[1:0], k[0], k[1:0], 3'b000};
            reg_wr(8'h73, v);
            cycles(3);
            chk("ami", 8'(ami_coding_o[7]), 8'(k[1] & k[0]));
            chk("ohms", rx_resistor_ohms_o[7], exp_ohm(k[1:0]));
            rd_chk(8'h73, v);
        end
        // separate copy per channel, writes one idle cycle apart
        for (int c = 0; c < NCH; c++) begin
            reg_wr({c[3:0], 4'h2}, 8'(c * 16 + 5));
        end
        for (int c = 0; c < NCH; c++) begin
            rd_chk({c[3:0], 4'h2}, 8'(c * 16 + 5));
        end
        // unmapped places answer zero and do not alias onto channel 0
        reg_wr(8'hE2, 8'hFF);
        rd_chk(8'hE2, lcr_pkg::REG_UNMAPPED_DATA);
        rd_chk(8'h04, lcr_pkg::REG_UNMAPPED_DATA);
        rd_chk(8'h00, lcr_pkg::REG_UNMAPPED_DATA);
        rd_chk(8'h02, 8'h05);
        // violation insertion, one pulse per rise of the bit
        reg_wr(8'h03, 8'h04);
        transmit_clock_run(0, 3, hits);
        chk("violations first", 8'(hits), 8'h01);
        transmit_clock_run(0, 2, hits);
        chk("violations held", 8'(hits), 8'h00);
        reg_wr(8'h03, 8'h00);
        transmit_clock_run(0, 1, hits);
        chk("violations cleared", 8'(hits), 8'h00);
        reg_wr(8'h03, 8'h04);
        transmit_clock_run(0, 2, hits);
        chk("violations again", 8'(hits), 8'h01);
        // second reset in mid-run clears everything again
        rst_n_i = 1'b0;
        cycles(2);
        rst_n_i = 1'b1;
        cycles(6);
        chk("tx power after reset", 8'(tx_power_on_o[0]), 8'h00);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h73, 8'h00);
        final_report();
    end
endmodule : lcr_channel_regs_tb
